/* rtl/sfdl_top.sv */
// Supply fault detect logic: twelve detectors, warnings, filters and registers
`timescale 1ns/1ps
// Notes on behaviour
// - Per detector: under, excess or window fault
// - Thresholds held as 8-bit codes
// - Trip = bottom + span * code / 255
// - Four ranges with fixed bottom and span
// - Range choice limited per input kind
// - Under-limit releases above threshold plus hysteresis
// - Excess-level releases below threshold minus hysteresis
// - 5-bit hysteresis code, span * code / 255
// - Glitch filter ends each detector, 0-100 us
// - Pulses shorter than timeout are suppressed
// - Filter output lags input by timeout
// - Dual-function input: analog or logic, not both
// - Logic-mode dual input lends detector to partner
// - Secondary shares primary range, raises ORed warnings
// - All delays from 100 kHz internal tick
module sfdl_top (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic [sfdl_pkg::ADDR_W-1:0]           addr,
  input  wire logic [sfdl_pkg::DATA_W-1:0]           wdata,
  input  wire logic                                  wr,
  input  wire logic                                  rd,
  input  wire logic [sfdl_pkg::NCH-1:0][sfdl_pkg::MV_W-1:0] level_mv,
  input  wire logic [sfdl_pkg::NVX-1:0]              dual_in,
  output logic [sfdl_pkg::DATA_W-1:0]                rdata,
  output logic [sfdl_pkg::NCH-1:0]                   under_limit_fault,
  output logic [sfdl_pkg::NCH-1:0]                   excess_level_fault,
  output logic [sfdl_pkg::NVX-1:0]                   warn,
  output logic                                       warn_any,
  output logic [sfdl_pkg::NVX-1:0]                   logic_in,
  output logic                                       irq
);
  localparam int NCH  = sfdl_pkg::NCH;
  localparam int NVX  = sfdl_pkg::NVX;
  localparam int NDET = sfdl_pkg::NDET;

  // Range allowed on each input kind; an illegal request falls back
  function automatic logic [1:0] legal_range(input int ch, input logic [1:0] req);
    if (ch == sfdl_pkg::CH_HV) begin
      legal_range = (req < sfdl_pkg::RNG_MID) ? sfdl_pkg::RNG_MID : req;
    end else if (ch < sfdl_pkg::CH_VX0) begin
      legal_range = (req == sfdl_pkg::RNG_HIGH) ? sfdl_pkg::RNG_MID : req;
    end else begin
      legal_range = sfdl_pkg::RNG_ULTRA;
    end
  endfunction

  // Primary input that a logic-mode dual-function input watches
  function automatic int pair_ch(input int k);
    pair_ch = (k < NVX - 1) ? k + 1 : sfdl_pkg::CH_HV;
  endfunction

  function automatic logic in_block(input logic [5:0] a, input logic [5:0] base);
    in_block = a[5:3] == base[5:3];
  endfunction

  // Register storage
  logic [sfdl_pkg::DATA_W-1:0] cfg_reg   [NCH];
  logic [sfdl_pkg::CODE_W-1:0] uv_th_reg [NCH];
  logic [sfdl_pkg::CODE_W-1:0] ov_th_reg [NCH];
  logic [sfdl_pkg::IRQ_W-1:0]  stat_reg;
  logic [sfdl_pkg::IRQ_W-1:0]  stat_next;
  logic [sfdl_pkg::IRQ_W-1:0]  mask_reg;
  logic [sfdl_pkg::DATA_W-1:0] rdata_reg;
  logic [sfdl_pkg::DATA_W-1:0] rd_mux;
  logic                        irq_reg;

  // Oscillator tick
  logic [sfdl_pkg::DIV_W-1:0]  div_reg;
  logic                        tick_reg;

  // Detector outputs
  logic [NDET-1:0]             uv_raw;
  logic [NDET-1:0]             ov_raw;
  logic [NDET-1:0]             uv_filt;
  logic [NDET-1:0]             ov_filt;
  logic [NVX-1:0]              dig_filt;
  logic [1:0]                  eff_range [NCH];
  logic [sfdl_pkg::FILT_W-1:0] filt_ticks [NCH];
  logic [NVX-1:0]              analog_sel;

  // Flag registers behind the outputs
  logic [NCH-1:0]              uv_flag_reg;
  logic [NCH-1:0]              ov_flag_reg;
  logic [NVX-1:0]              warn_reg;
  logic                        warn_any_reg;
  logic [NVX-1:0]              logic_in_reg;
  logic [NCH-1:0]              fault_prev_reg;
  logic                        warn_prev_reg;
  logic [NCH-1:0]              uv_flag_next;
  logic [NCH-1:0]              ov_flag_next;
  logic [NVX-1:0]              warn_next;
  logic [NVX-1:0]              logic_in_next;

  wire                         cfg_we  = wr && in_block(addr, sfdl_pkg::ADDR_CFG_BASE);
  wire                         uv_we   = wr && in_block(addr, sfdl_pkg::ADDR_UV_BASE);
  wire                         ov_we   = wr && in_block(addr, sfdl_pkg::ADDR_OV_BASE);
  wire                         stat_we = wr && addr == sfdl_pkg::ADDR_IRQ_STAT;
  wire                         mask_we = wr && addr == sfdl_pkg::ADDR_IRQ_MASK;
  wire [2:0]                   idx     = addr[2:0];

  // Divide the system clock down to the 100 kHz timing tick
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= (div_reg == sfdl_pkg::OSC_LAST) ? '0 : div_reg + 8'h01;
      tick_reg <= div_reg == sfdl_pkg::OSC_LAST;
    end
  end

  // Per-channel decode of configuration fields
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      wire [sfdl_pkg::FILT_W-1:0] req_ticks = cfg_reg[c][sfdl_pkg::CFG_FILT_LSB +: 4];
      assign eff_range[c] = legal_range(c, cfg_reg[c][sfdl_pkg::CFG_RANGE_LSB +: 2]);
      // Codes above the documented maximum are held at 100 us
      assign filt_ticks[c] = (req_ticks > sfdl_pkg::FILT_MAX) ? sfdl_pkg::FILT_MAX
                                                                : req_ticks;
    end
    for (c = 0; c < NVX; c++) begin : g_sel
      assign analog_sel[c] = cfg_reg[sfdl_pkg::CH_VX0 + c][sfdl_pkg::CFG_ANALOG_BIT];
    end
  endgenerate

  // Detectors 0..7 are primaries, 8..11 the borrowed secondaries
  genvar d;
  generate
    for (d = 0; d < NDET; d++) begin : g_det
      localparam int SRC = (d < NCH) ? d : pair_ch(d - NCH);
      localparam int CFG = (d < NCH) ? d : d - NVX;
      wire en_det;
      if (d < sfdl_pkg::CH_VX0) begin : g_ded
        assign en_det = 1'b1;
      end else if (d < NCH) begin : g_dual
        assign en_det = analog_sel[d - sfdl_pkg::CH_VX0];
      end else begin : g_sec
        assign en_det = !analog_sel[d - NCH];
      end
      sfdl_cmp u_cmp (
        .clk       (clk),
        .rst       (rst),
        .en        (en_det),
        .mode      (cfg_reg[CFG][sfdl_pkg::CFG_MODE_LSB +: 2]),
        .range     (eff_range[SRC]),
        .uv_code   (uv_th_reg[CFG]),
        .ov_code   (ov_th_reg[CFG]),
        .hyst_code (cfg_reg[CFG][sfdl_pkg::CFG_HYST_LSB +: 5]),
        .level_mv  (level_mv[SRC]),
        .uv_raw    (uv_raw[d]),
        .ov_raw    (ov_raw[d])
      );
      sfdl_glitch u_flt_uv (
        .clk     (clk),
        .rst     (rst),
        .tick    (tick_reg),
        .timeout (filt_ticks[CFG]),
        .din     (uv_raw[d]),
        .dout    (uv_filt[d])
      );
      sfdl_glitch u_flt_ov (
        .clk     (clk),
        .rst     (rst),
        .tick    (tick_reg),
        .timeout (filt_ticks[CFG]),
        .din     (ov_raw[d]),
        .dout    (ov_filt[d])
      );
    end
    for (d = 0; d < NVX; d++) begin : g_dig
      sfdl_glitch u_flt_dig (
        .clk     (clk),
        .rst     (rst),
        .tick    (tick_reg),
        .timeout (filt_ticks[sfdl_pkg::CH_VX0 + d]),
        .din     (dual_in[d] && !analog_sel[d]),
        .dout    (dig_filt[d])
      );
    end
  endgenerate

  // Route filtered flags: faults from primaries, warnings from secondaries
  assign uv_flag_next  = uv_filt[NCH-1:0] & {analog_sel, 4'hf};
  assign ov_flag_next  = ov_filt[NCH-1:0] & {analog_sel, 4'hf};
  assign warn_next     = (uv_filt[NDET-1:NCH] | ov_filt[NDET-1:NCH]) & ~analog_sel;
  assign logic_in_next = dig_filt & ~analog_sel;

  always_ff @(posedge clk) begin
    if (rst) begin
      uv_flag_reg    <= '0;
      ov_flag_reg    <= '0;
      warn_reg       <= '0;
      warn_any_reg   <= 1'b0;
      logic_in_reg   <= '0;
      fault_prev_reg <= '0;
      warn_prev_reg  <= 1'b0;
    end else begin
      uv_flag_reg    <= uv_flag_next;
      ov_flag_reg    <= ov_flag_next;
      warn_reg       <= warn_next;
      warn_any_reg   <= |warn_next;
      logic_in_reg   <= logic_in_next;
      fault_prev_reg <= uv_flag_reg | ov_flag_reg;
      warn_prev_reg  <= warn_any_reg;
    end
  end

  // Rising faults and warnings are sticky; a new event beats a W1C in the same cycle
  wire [sfdl_pkg::IRQ_W-1:0] events = {warn_any_reg & ~warn_prev_reg,
                                       (uv_flag_reg | ov_flag_reg) & ~fault_prev_reg};
  wire [sfdl_pkg::IRQ_W-1:0] w1c    = stat_we ? wdata[sfdl_pkg::IRQ_W-1:0] : '0;
  assign stat_next = (stat_reg & ~w1c) | events;

  // Configuration and interrupt registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i]   <= sfdl_pkg::CFG_RESET;
        uv_th_reg[i] <= sfdl_pkg::TH_RESET;
        ov_th_reg[i] <= sfdl_pkg::TH_RESET;
      end
      stat_reg <= sfdl_pkg::IRQ_RESET;
      mask_reg <= sfdl_pkg::IRQ_RESET;
      irq_reg  <= 1'b0;
    end else begin
      if (cfg_we) begin
        cfg_reg[idx] <= wdata & sfdl_pkg::CFG_WMASK;
      end
      if (uv_we) begin
        uv_th_reg[idx] <= wdata[sfdl_pkg::CODE_W-1:0];
      end
      if (ov_we) begin
        ov_th_reg[idx] <= wdata[sfdl_pkg::CODE_W-1:0];
      end
      if (mask_we) begin
        mask_reg <= wdata[sfdl_pkg::IRQ_W-1:0];
      end
      stat_reg <= stat_next;
      irq_reg  <= |(stat_next & (mask_we ? wdata[sfdl_pkg::IRQ_W-1:0] : mask_reg));
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    if (in_block(addr, sfdl_pkg::ADDR_CFG_BASE)) begin
      rd_mux = cfg_reg[idx];
    end else if (in_block(addr, sfdl_pkg::ADDR_UV_BASE)) begin
      rd_mux = {8'h00, uv_th_reg[idx]};
    end else if (in_block(addr, sfdl_pkg::ADDR_OV_BASE)) begin
      rd_mux = {8'h00, ov_th_reg[idx]};
    end else if (addr == sfdl_pkg::ADDR_FAULT) begin
      rd_mux = {ov_flag_reg, uv_flag_reg};
    end else if (addr == sfdl_pkg::ADDR_WARN) begin
      rd_mux = {8'h00, logic_in_reg, warn_reg};
    end else if (addr == sfdl_pkg::ADDR_IRQ_STAT) begin
      rd_mux = {7'h00, stat_reg};
    end else if (addr == sfdl_pkg::ADDR_IRQ_MASK) begin
      rd_mux = {7'h00, mask_reg};
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd ? rd_mux : '0;
    end
  end

  assign rdata              = rdata_reg;
  assign under_limit_fault  = uv_flag_reg;
  assign excess_level_fault = ov_flag_reg;
  assign warn               = warn_reg;
  assign warn_any           = warn_any_reg;
  assign logic_in           = logic_in_reg;
  assign irq                = irq_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_spacing: assert property (tick_reg |=> !tick_reg [*8])
    else $error("oscillator tick too frequent");
  a_dual_exclusive: assert property (((uv_flag_reg[7:4] | ov_flag_reg[7:4]) & ~analog_sel) == 4'h0
                                     || $changed(analog_sel) || $past($changed(analog_sel)))
    else $error("logic-mode input reports an analog fault");
  a_logic_exclusive: assert property (##1 !$changed(analog_sel) |-> (logic_in_reg & analog_sel) == 4'h0)
    else $error("analog-mode input reports a logic level");
  a_warn_or: assert property (warn_any_reg == $past(|warn_next))
    else $error("combined warning does not follow warning bits");
  a_range_legal: assert property (eff_range[0] >= 2'h2 && eff_range[1] != 2'h3
                                  && eff_range[4] == 2'h0)
    else $error("detector uses a range its input lacks");
  a_irq_level: assert property (irq_reg == $past(|(stat_next & (mask_we ? wdata[8:0] : mask_reg))))
    else $error("interrupt output disagrees with masked status");


  // Read data stands only in the cycle after the strobe, zero otherwise
  a_rdata_idle: assert property (!$past(rd) |-> rdata_reg == 16'h0000)
    else $error("read data present without a read strobe");
  a_rdata_value: assert property ($past(rd) |-> rdata_reg == $past(rd_mux))
    else $error("read data differs from addressed register");

  // Output flags are plain registers behind the tick-domain filters
  a_uv_flag_reg: assert property (uv_flag_reg == $past(uv_flag_next))
    else $error("under-limit flag not registered from its filter");
  a_ov_flag_reg: assert property (ov_flag_reg == $past(ov_flag_next))
    else $error("excess-level flag not registered from its filter");

  // Sticky status; an event in the clearing cycle must survive
  a_stat_sticky: assert property (stat_reg == (($past(stat_reg) & ~$past(w1c))
                                               | $past(events)))
    else $error("status register lost or invented an event");

  // Warnings only from inputs lent out in logic mode
  a_warn_gate: assert property ((warn_reg & $past(analog_sel)) == 4'h0)
    else $error("warning raised by an analog-mode input");

  c_under_fault: cover property (!uv_flag_reg[1] ##1 uv_flag_reg[1]);
  c_excess_fault: cover property (!ov_flag_reg[0] ##1 ov_flag_reg[0]);
  c_logic_level: cover property (!logic_in_reg[0] ##1 logic_in_reg[0]);
  c_warning: cover property (!warn_any_reg ##1 warn_any_reg);
  c_irq: cover property (!irq_reg ##1 irq_reg);
endmodule // sfdl_top

/* rtl/sfdl_pkg.sv */
// Constants, types and scaling helpers for the supply fault detect logic
package sfdl_pkg;

  localparam int CLK_HZ         = 20_000_000;
  localparam int OSC_HZ         = 100_000;
  localparam int OSC_DIV        = CLK_HZ / OSC_HZ;
  localparam int OSC_PERIOD_US  = 1_000_000 / OSC_HZ;
  localparam int FILT_MAX_US    = 100;
  localparam int FILT_MAX_TICKS = FILT_MAX_US / OSC_PERIOD_US;

  localparam int NCH    = 8;
  localparam int NVX    = 4;
  localparam int NDET   = NCH + NVX;
  localparam int MV_W   = 16;
  localparam int CODE_W = 8;
  localparam int HYST_W = 5;
  localparam int FILT_W = 4;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int DIV_W  = 8;
  localparam int IRQ_W  = 9;

  localparam logic [23:0] CODE_FULL = 24'h0000ff;
  localparam logic [DIV_W-1:0] OSC_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(FILT_MAX_TICKS);

  localparam int CH_HV  = 0;
  localparam int CH_VX0 = 4;

  // Register map
  localparam logic [ADDR_W-1:0] ADDR_CFG_BASE = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_UV_BASE  = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_OV_BASE  = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_FAULT    = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_WARN     = 6'h19;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 6'h1a;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 6'h1b;

  // Channel configuration fields
  localparam int CFG_RANGE_LSB  = 0;
  localparam int CFG_MODE_LSB   = 2;
  localparam int CFG_HYST_LSB   = 4;
  localparam int CFG_FILT_LSB   = 9;
  localparam int CFG_ANALOG_BIT = 13;
  localparam logic [DATA_W-1:0] CFG_WMASK = 16'h3fff;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
  localparam logic [CODE_W-1:0] TH_RESET  = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RESET = 9'h000;

  typedef enum logic [1:0] {
    RNG_ULTRA = 2'b00,
    RNG_LOW   = 2'b01,
    RNG_MID   = 2'b10,
    RNG_HIGH  = 2'b11
  } sfdl_range_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_UV  = 2'b01,
    MODE_OV  = 2'b10,
    MODE_WIN = 2'b11
  } sfdl_mode_t;

  // Range bottom and span in millivolts
  localparam logic [MV_W-1:0] BOT_ULTRA  = 16'd573;
  localparam logic [MV_W-1:0] SPAN_ULTRA = 16'd802;
  localparam logic [MV_W-1:0] BOT_LOW    = 16'd1250;
  localparam logic [MV_W-1:0] SPAN_LOW   = 16'd1750;
  localparam logic [MV_W-1:0] BOT_MID    = 16'd2500;
  localparam logic [MV_W-1:0] SPAN_MID   = 16'd3500;
  localparam logic [MV_W-1:0] BOT_HIGH   = 16'd4800;
  localparam logic [MV_W-1:0] SPAN_HIGH  = 16'd9600;

  function automatic logic [MV_W-1:0] range_bot(input sfdl_range_t r);
    case (r)
      RNG_ULTRA: range_bot = BOT_ULTRA;
      RNG_LOW:   range_bot = BOT_LOW;
      RNG_MID:   range_bot = BOT_MID;
      default:   range_bot = BOT_HIGH;
    endcase
  endfunction

  function automatic logic [MV_W-1:0] range_span(input sfdl_range_t r);
    case (r)
      RNG_ULTRA: range_span = SPAN_ULTRA;
      RNG_LOW:   range_span = SPAN_LOW;
      RNG_MID:   range_span = SPAN_MID;
      default:   range_span = SPAN_HIGH;
    endcase
  endfunction

  // Span times code over 255, truncated to whole millivolts
  function automatic logic [MV_W-1:0] scale_mv(input logic [MV_W-1:0] span,
                                               input logic [CODE_W-1:0] code);
    logic [23:0] prod;
    prod = 24'(span) * 24'(code);
    scale_mv = MV_W'(prod / CODE_FULL);
  endfunction

endpackage

/* rtl/sfdl_glitch.sv */
// Tick-driven glitch filter for one comparator or logic input
`timescale 1ns/1ps
module sfdl_glitch (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       tick,
  input  wire logic [sfdl_pkg::FILT_W-1:0] timeout,
  input  wire logic                       din,
  output logic                            dout
);
  logic [sfdl_pkg::FILT_W-1:0] cnt_reg;
  logic                        out_reg;
  wire                         differ = din != out_reg;
  wire                         expire = ({1'b0, cnt_reg} + 5'h01) >= {1'b0, timeout};

  // Output is the oscillator-domain flag register itself
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else if (tick) begin
      if (!differ) begin
        cnt_reg <= '0;
      end else if (expire) begin
        out_reg <= din;
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
  assign dout = out_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_glitch_block: assert property (tick && differ && !expire |=> out_reg == $past(out_reg))
    else $error("glitch filter passed a short pulse");
  a_glitch_pass: assert property (tick && differ && expire |=> out_reg == $past(din))
    else $error("glitch filter missed its timeout");
endmodule // sfdl_glitch

/* rtl/sfdl_cmp.sv */
// Threshold comparison with post-fault hysteresis for one detector
`timescale 1ns/1ps
module sfdl_cmp (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        en,
  input  wire logic [1:0]                  mode,
  input  wire logic [1:0]                  range,
  input  wire logic [sfdl_pkg::CODE_W-1:0] uv_code,
  input  wire logic [sfdl_pkg::CODE_W-1:0] ov_code,
  input  wire logic [sfdl_pkg::HYST_W-1:0] hyst_code,
  input  wire logic [sfdl_pkg::MV_W-1:0]   level_mv,
  output logic                             uv_raw,
  output logic                             ov_raw
);
  logic        uv_reg;
  logic        ov_reg;
  logic        uv_next;
  logic        ov_next;
  wire sfdl_pkg::sfdl_range_t rng = sfdl_pkg::sfdl_range_t'(range);
  wire [15:0]  bot  = sfdl_pkg::range_bot(rng);
  wire [15:0]  span = sfdl_pkg::range_span(rng);
  wire [15:0]  trip_uv = bot + sfdl_pkg::scale_mv(span, uv_code);
  wire [15:0]  trip_ov = bot + sfdl_pkg::scale_mv(span, ov_code);
  wire [15:0]  hyst = sfdl_pkg::scale_mv(span, {3'h0, hyst_code});
  wire         uv_en = en && (mode == sfdl_pkg::MODE_UV || mode == sfdl_pkg::MODE_WIN);
  wire         ov_en = en && (mode == sfdl_pkg::MODE_OV || mode == sfdl_pkg::MODE_WIN);
  wire         uv_clr = {1'b0, level_mv} > ({1'b0, trip_uv} + {1'b0, hyst});
  wire         ov_clr = ({1'b0, level_mv} + {1'b0, hyst}) < {1'b0, trip_ov};

  // Hysteresis only moves the release point, never the trip point
  assign uv_next = !uv_en ? 1'b0 : (uv_reg ? !uv_clr : level_mv < trip_uv);
  assign ov_next = !ov_en ? 1'b0 : (ov_reg ? !ov_clr : level_mv > trip_ov);

  always_ff @(posedge clk) begin
    if (rst) begin
      uv_reg <= 1'b0;
      ov_reg <= 1'b0;
    end else begin
      uv_reg <= uv_next;
      ov_reg <= ov_next;
    end
  end
  assign uv_raw = uv_reg;
  assign ov_raw = ov_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_uv_trip: assert property (uv_en && !uv_reg && level_mv < trip_uv |=> uv_reg)
    else $error("under-limit fault did not trip");
  a_uv_hyst_hold: assert property (uv_reg && uv_en && !uv_clr |=> uv_reg)
    else $error("under-limit fault released inside hysteresis");
  a_ov_hyst_hold: assert property (ov_reg && ov_en && !ov_clr |=> ov_reg)
    else $error("excess-level fault released inside hysteresis");
  a_mode_gate: assert property (!uv_en && !ov_en |=> !uv_reg && !ov_reg)
    else $error("fault flagged on a disabled limit");
endmodule // sfdl_cmp

/* bench/sfdl_rails.sv */
// Model of the supervised rails and logic pins seen by the detectors
`timescale 1ns/1ps
module sfdl_rails (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic                                    set_en,
  input  wire logic [2:0]                              set_ch,
  input  wire logic [15:0]                             set_mv,
  input  wire logic [3:0]                              pins,
  output logic [sfdl_pkg::NCH-1:0][sfdl_pkg::MV_W-1:0] level_mv,
  output logic [sfdl_pkg::NVX-1:0]                     dual_in
);
  // Rails come up at 3 V so that no default range trips
  always_ff @(posedge clk) begin
    if (rst) begin
      level_mv <= {8{16'h0bb8}};
      dual_in  <= 4'h0;
    end else begin
      if (set_en) begin
        level_mv[set_ch] <= set_mv;
      end
      dual_in <= pins;
    end
  end
endmodule // sfdl_rails

/* bench/sfdl_top_tb.sv */
// Self-checking bench for the supply fault detect logic
`timescale 1ns/1ps
module sfdl_top_tb;
  logic             clk, irq, warn_any, rst = 1'b1, wr = 1'b0, rd = 1'b0, set_en = 1'b0;
  logic [5:0]       addr = 6'h00;
  logic [15:0]      rdata, wdata = 16'h0000, set_mv = 16'h0000;
  logic [2:0]       set_ch = 3'h0;
  logic [7:0]       ulf, elf;
  logic [3:0]       warn, logic_in, dual_in, pins = 4'h0;
  logic [7:0][15:0] level_mv;
  logic [31:0]      seed = 32'hd793;
  int               miscompares = 0, cmp_count = 0;

  sfdl_rails u_rails (.clk(clk), .rst(rst), .set_en(set_en), .set_ch(set_ch), .set_mv(set_mv),
    .pins(pins), .level_mv(level_mv), .dual_in(dual_in));
  sfdl_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .level_mv(level_mv), .dual_in(dual_in), .rdata(rdata), .under_limit_fault(ulf),
    .excess_level_fault(elf), .warn(warn), .warn_any(warn_any), .logic_in(logic_in), .irq(irq));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int trip(int bot, int span, int code);
    return bot + span * code / 255;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input int a, input int d);
    @(posedge clk);
    addr <= 6'(a);
    wdata <= 16'(d);
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input int a, output logic [15:0] d);
    @(posedge clk);
    addr <= 6'(a);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rail(input int ch, input int mv);
    @(posedge clk);
    set_en <= 1'b1;
    set_ch <= 3'(ch);
    set_mv <= 16'(mv);
    @(posedge clk);
    set_en <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n * sfdl_pkg::OSC_DIV) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Walk one detector through trip, hold inside hysteresis and release
  task automatic det(input int ch, input int rc, input int bot, input int span, input bit ov);
    int c, h, t, hy, ta;
    int lv[4];
    logic [15:0] d;
    c = 20 + int'(rnd() % 200);
    h = int'(rnd() % 32);
    t = trip(bot, span, c);
    hy = trip(0, span, h);
    ta = ov ? 16 + ch : 8 + ch;
    lv = '{0, 1, -hy, -hy - 1};
    rail(ch, ov ? t - hy - 1 : t + hy + 1);
    wr_reg(ta, c);
    wr_reg(ch, h * 16 + (ov ? 8 : 4) + rc + (ch > 3 ? 8192 : 0));
    rd_reg(ta, d);
    chk(d, 16'(c));
    for (int i = 0; i < 4; i++) begin
      rail(ch, ov ? t + lv[i] : t - lv[i]);
      ticks(2);
      chk(16'(ov ? elf[ch] : ulf[ch]), 16'(i == 1 || i == 2));
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run needs about 17k cycles
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial begin
    logic [15:0] d;
    int n;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 30; a++) begin
      rd_reg(a == 29 ? 63 : a, d);
      chk(d, 16'h0000);
    end
    wr_reg(27, 2);
    det(1, 1, 1250, 1750, 0);
    rd_reg(26, d);
    chk(d & 16'h0002, 16'h0002);
    chk(16'(irq), 16'h0001);
    wr_reg(26, 511);
    repeat (3) @(posedge clk);
    chk(16'(irq), 16'h0000);
    det(0, 0, 2500, 3500, 1);
    chk(16'(irq), 16'h0000);
    det(0, 3, 4800, 9600, 1);
    det(2, 2, 2500, 3500, 0);
    det(5, 3, 573, 802, 0);
    wr_reg(11, 64);
    wr_reg(19, 192);
    for (int m = 0; m < 4; m++) begin
      wr_reg(3, m * 4 + 2);
      rail(3, 3000);
      ticks(2);
      chk(16'(ulf[3]), 16'(m % 2));
      rail(3, 6000);
      ticks(2);
      chk(16'(elf[3]), 16'(m / 2));
      rail(3, 4000);
      ticks(2);
    end
    // Filter of four ticks: a two-tick dip must vanish
    wr_reg(3, 2048 + 6);
    rail(3, 3000);
    ticks(2);
    rail(3, 4000);
    repeat (6) begin
      ticks(1);
      chk(16'(ulf[3]), 16'h0000);
    end
    rail(3, 3000);
    n = 0;
    while (ulf[3] !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n >= 600 && n <= 805), 16'h0001);
    wr_reg(27, 256);
    wr_reg(12, 128);
    wr_reg(4, 4);
    rail(1, 2000);
    ticks(2);
    chk(16'(warn), 16'h0001);
    chk(16'(warn_any), 16'h0001);
    chk(16'(ulf[4]), 16'h0000);
    chk(16'(irq), 16'h0001);
    rd_reg(25, d);
    chk(d & 16'h000f, 16'h0001);
    @(posedge clk);
    pins <= 4'h1;
    ticks(2);
    chk(16'(logic_in), 16'h0001);
    wr_reg(4, 8192 + 4);
    ticks(2);
    chk(16'(warn), 16'h0000);
    chk(16'(logic_in), 16'h0000);
    end_sim();
  end
endmodule // sfdl_top_tb
